// *** common/cifd_consts.svh ***
`ifndef CIFD_CONSTS_SVH
`define CIFD_CONSTS_SVH

// ------------------------------------------------------------
// Reset values and field masks
// ------------------------------------------------------------
`define CIFD_INT_RST   32'h0000_0000
`define CIFD_EN_MASK   32'hFF1F_0000
`define CIFD_CLR_MASK  32'h0000_F00C
`define CIFD_EN_SHIFT  16
`define CIFD_FIFO_NUM  32

// ------------------------------------------------------------
// Flag bit positions
// ------------------------------------------------------------
`define CIFD_B_BADMSG  15
`define CIFD_B_WAKE    14
`define CIFD_B_BUSERR  13
`define CIFD_B_SYSF    12
`define CIFD_B_RXOVR   11
`define CIFD_B_TXATT   10
`define CIFD_B_LINKCK  9
`define CIFD_B_MEMCOR  8
`define CIFD_B_TEQ     4
`define CIFD_B_MODE    3
`define CIFD_B_TBWRAP  2
`define CIFD_B_RXQ     1
`define CIFD_B_TXQ     0

// ------------------------------------------------------------
// Interrupt codes
// ------------------------------------------------------------
`define CIFD_CODE_NONE   7'h40
`define CIFD_CODE_BUSERR 7'h41
`define CIFD_CODE_WAKE   7'h42
`define CIFD_CODE_RXOVR  7'h43
`define CIFD_CODE_SYSF   7'h44
`define CIFD_CODE_TBWRAP 7'h46
`define CIFD_CODE_MODE   7'h47
`define CIFD_CODE_BADMSG 7'h48
`define CIFD_CODE_TEQ    7'h49
`define CIFD_CODE_TXATT  7'h4A

`endif

// *** common/cifd_pkg.sv ***
package cifd_pkg;

    // Register selection on the register port
    typedef enum logic [1:0] {
        CIFD_SEL_INT  = 2'h0,
        CIFD_SEL_RXP  = 2'h1,
        CIFD_SEL_RXOV = 2'h2
    } cifd_sel_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        cifd_sel_e   sel;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cifd_req_s;

    typedef struct packed {
        logic bad_message;
        logic bus_wakeup;
        logic bus_error;
        logic system_fault;
    } cifd_evt_s;

    typedef struct packed {
        logic [2:0] rx_flag;
        logic [2:0] rx_en;
        logic [2:0] tx_flag;
        logic [2:0] tx_en;
        logic       ovf;
    } cifd_fifo_s;

    typedef struct packed {
        logic [31:0] rx_queue_pending_vec;
        logic [31:0] rx_overrun_pending_vec;
        logic [31:0] tx_queue_pending_vec;
    } cifd_vec_s;

    typedef struct packed {
        logic [6:0] rx;
        logic [6:0] tx;
        logic [6:0] icode;
    } cifd_code_s;

endpackage

// *** design/cifd_code_enc.sv ***
`timescale 1ns/10ps
module cifd_code_enc
    import cifd_pkg::*;
(
    // Pending vectors
    input  wire logic [31:0] rx_vec_i,
    input  wire logic [31:0] tx_vec_i,
    input  wire logic [31:0] fifo_vec_i,
    // Codes of highest pending entry
    output logic      [6:0]  rx_code_o,
    output logic      [6:0]  tx_code_o,
    output logic      [6:0]  fifo_code_o
);
    `include "cifd_consts.svh"

    function automatic logic [6:0] hi_code(input logic [31:0] v);
        logic [6:0] c;
        c = `CIFD_CODE_NONE;
        for (int i = 0; i < `CIFD_FIFO_NUM; i++)
        begin
            if (v[i])
            begin
                c = 7'(i);
            end
        end
        return c;
    endfunction

    always_comb
    begin
        rx_code_o   = hi_code(rx_vec_i);
        tx_code_o   = hi_code(tx_vec_i);
        fifo_code_o = hi_code(fifo_vec_i);
    end
endmodule

// *** design/cifd_flag_reg.sv ***
`timescale 1ns/10ps
module cifd_flag_reg (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Set and clear requests
    input  wire logic [5:0] set_i,
    input  wire logic [5:0] clr_i,
    // Flag state
    output logic      [5:0] q_o
);
    logic [5:0] flag_q;
    logic [5:0] flag_d;

    always_comb
    begin
        flag_d = (flag_q & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            flag_q <= 6'h00;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign q_o = flag_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    flag_set_wins_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (|set_i) |=> ((q_o & $past(set_i)) == $past(set_i)))
        else $error("set flag not taken");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 (($past(q_o) & ~$past(clr_i) & ~q_o) == 6'h00))
        else $error("flag dropped without clear");
endmodule

// *** design/cifd_int_top.sv ***
`timescale 1ns/10ps
// Functional notes
// - Enables for fault events at bits 31..24
// - Enables for queue/mode/timebase at bits 20..16
// - Event flags set by hardware, host clears
// - Bad message, wakeup, bus error at 15..13
// - System fault flag at bit 12
// - Read-only summaries at bits 11..8
// - Bit 4 shows pending transmit event queue
// - Bit 3 set on operating mode change
// - Bit 2 set on time base wrap
// - Bit 1 shows any receive queue pending
// - Bit 0 shows any transmit queue pending
// - Unimplemented bits always read zero
// - Receive pending equals OR of enabled flags
// - Per-FIFO receive overrun pending bits 31..1
// - Transmit pending per FIFO, bit 0 priority
// - Codes report highest pending, else none
module cifd_int_top
    import cifd_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    // Register port
    input  wire cifd_pkg::cifd_req_s    reg_req_i,
    output logic               [31:0]   reg_rdata_o,
    output logic                        reg_rvalid_o,
    // Event sources
    input  wire cifd_pkg::cifd_evt_s    evt_i,
    input  wire logic          [2:0]    operating_mode_field_i,
    input  wire logic          [31:0]   time_base_counter_i,
    // FIFO state
    input  wire cifd_pkg::cifd_fifo_s [31:0] fifo_i,
    input  wire logic          [31:0]   tx_attempt_vec_i,
    input  wire logic                   tx_event_queue_pend_i,
    input  wire logic                   host_link_check_pend_i,
    input  wire logic                   memory_correct_pend_i,
    // Status and request
    output cifd_pkg::cifd_vec_s         vec_o,
    output cifd_pkg::cifd_code_s        code_o,
    output logic                        irq_o
);
    import cifd_pkg::*;
    `include "cifd_consts.svh"

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] rx_or(input cifd_fifo_s [31:0] f);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 1; i < `CIFD_FIFO_NUM; i++)
        begin
            v[i] = |(f[i].rx_flag & f[i].rx_en);
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] en_q;
    logic [31:0] en_d;
    logic [31:0] rxp_q;
    logic [31:0] rxp_d;
    logic [31:0] rxov_q;
    logic [31:0] rxov_d;
    logic [31:0] txp_q;
    logic [31:0] txp_d;
    logic [2:0]  ro_q;
    logic [2:0]  ro_d;
    logic        tef_q;
    logic        tef_d;
    logic [2:0]  mode_q;
    logic [2:0]  mode_d;
    logic        prime_q;
    logic        prime_d;
    logic        tb_full_q;
    logic        tb_full_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;
    cifd_code_s  code_q;
    cifd_code_s  code_d;

    logic        int_wr;
    logic [31:0] wmask;
    logic [5:0]  stk_set;
    logic [5:0]  stk_clr;
    logic [5:0]  stk;
    logic [31:0] int_rd;
    logic [6:0]  rx_code;
    logic [6:0]  tx_code;
    logic [6:0]  fifo_code;
    logic [31:0] fifo_pend;
    logic        mode_chg;
    logic        tb_wrap;

    // ------------------------------------------------------------
    // Event detection and sticky flags
    // ------------------------------------------------------------
    assign int_wr   = reg_req_i.valid && reg_req_i.write && (reg_req_i.sel == CIFD_SEL_INT);
    assign wmask    = lane_mask(reg_req_i.be);
    assign mode_chg = prime_q && (operating_mode_field_i != mode_q);
    assign tb_wrap  = tb_full_q && (time_base_counter_i == 32'h0000_0000);

    always_comb
    begin
        stk_set = {evt_i.bad_message, evt_i.bus_wakeup, evt_i.bus_error,
                   evt_i.system_fault, mode_chg, tb_wrap};
        stk_clr = 6'h00;
        if (int_wr)
        begin
            // Writing zero clears, writing one leaves the flag alone
            stk_clr = ~{reg_req_i.wdata[15:12], reg_req_i.wdata[3:2]}
                      & {wmask[15:12], wmask[3:2]};
        end
    end

    cifd_flag_reg u_flags (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .set_i   (stk_set),
        .clr_i   (stk_clr),
        .q_o     (stk)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        en_d = en_q;
        if (int_wr)
        begin
            en_d = (en_q & ~(wmask & `CIFD_EN_MASK))
                   | (reg_req_i.wdata & wmask & `CIFD_EN_MASK);
        end
        rxp_d  = rx_or(fifo_i);
        rxov_d = 32'h0000_0000;
        txp_d  = 32'h0000_0000;
        for (int i = 0; i < `CIFD_FIFO_NUM; i++)
        begin
            rxov_d[i] = (i != 0) && fifo_i[i].ovf;
            txp_d[i]  = |(fifo_i[i].tx_flag & fifo_i[i].tx_en);
        end
        ro_d      = {|tx_attempt_vec_i, host_link_check_pend_i, memory_correct_pend_i};
        tef_d     = tx_event_queue_pend_i;
        mode_d    = operating_mode_field_i;
        prime_d   = 1'b1;
        tb_full_d = &time_base_counter_i;
    end

    // ------------------------------------------------------------
    // Interrupt register view
    // ------------------------------------------------------------
    always_comb
    begin
        int_rd = {en_q[31:24], 3'h0, en_q[20:16],
                  stk[5:2],
                  |rxov_q, ro_q,
                  3'h0, tef_q, stk[1:0],
                  |rxp_q, |txp_q};
    end

    assign irq_o = |(int_rd[15:0] & int_rd[31:16]);

    // ------------------------------------------------------------
    // Interrupt codes
    // ------------------------------------------------------------
    assign fifo_pend = (rxp_q & {32{en_q[17]}}) | (txp_q & {32{en_q[16]}});

    cifd_code_enc u_enc (
        .rx_vec_i    (rxp_q),
        .tx_vec_i    (txp_q),
        .fifo_vec_i  (fifo_pend),
        .rx_code_o   (rx_code),
        .tx_code_o   (tx_code),
        .fifo_code_o (fifo_code)
    );

    always_comb
    begin
        code_d.rx = rx_code;
        code_d.tx = tx_code;
        // Highest code number wins
        if (int_rd[10] && int_rd[26])
        begin
            code_d.icode = `CIFD_CODE_TXATT;
        end
        else if (int_rd[4] && int_rd[20])
        begin
            code_d.icode = `CIFD_CODE_TEQ;
        end
        else if (int_rd[15] && int_rd[31])
        begin
            code_d.icode = `CIFD_CODE_BADMSG;
        end
        else if (int_rd[3] && int_rd[19])
        begin
            code_d.icode = `CIFD_CODE_MODE;
        end
        else if (int_rd[2] && int_rd[18])
        begin
            code_d.icode = `CIFD_CODE_TBWRAP;
        end
        else if (int_rd[12] && int_rd[28])
        begin
            code_d.icode = `CIFD_CODE_SYSF;
        end
        else if (int_rd[11] && int_rd[27])
        begin
            code_d.icode = `CIFD_CODE_RXOVR;
        end
        else if (int_rd[14] && int_rd[30])
        begin
            code_d.icode = `CIFD_CODE_WAKE;
        end
        else if (int_rd[13] && int_rd[29])
        begin
            code_d.icode = `CIFD_CODE_BUSERR;
        end
        else
        begin
            code_d.icode = fifo_code;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb
    begin
        rvalid_d = reg_req_i.valid && !reg_req_i.write;
        rdata_d  = rdata_q;
        if (rvalid_d)
        begin
            unique case (reg_req_i.sel)
                CIFD_SEL_INT:  rdata_d = int_rd;
                CIFD_SEL_RXP:  rdata_d = rxp_q;
                CIFD_SEL_RXOV: rdata_d = rxov_q;
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            en_q      <= `CIFD_INT_RST;
            rxp_q     <= 32'h0000_0000;
            rxov_q    <= 32'h0000_0000;
            txp_q     <= 32'h0000_0000;
            ro_q      <= 3'h0;
            tef_q     <= 1'b0;
            mode_q    <= 3'h0;
            prime_q   <= 1'b0;
            tb_full_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rvalid_q  <= 1'b0;
            code_q    <= {`CIFD_CODE_NONE, `CIFD_CODE_NONE, `CIFD_CODE_NONE};
        end
        else
        begin
            en_q      <= en_d;
            rxp_q     <= rxp_d;
            rxov_q    <= rxov_d;
            txp_q     <= txp_d;
            ro_q      <= ro_d;
            tef_q     <= tef_d;
            mode_q    <= mode_d;
            prime_q   <= prime_d;
            tb_full_q <= tb_full_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            code_q    <= code_d;
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign code_o       = code_q;
    assign vec_o        = '{rx_queue_pending_vec:   rxp_q,
                            rx_overrun_pending_vec: rxov_q,
                            tx_queue_pending_vec:   txp_q};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    en_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (int_wr && reg_req_i.be == 4'hF)
        |=> ((int_rd & `CIFD_EN_MASK) == ($past(reg_req_i.wdata) & `CIFD_EN_MASK)))
        else $error("enable write not stored");
    en_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !int_wr |=> $stable(int_rd[20:16]))
        else $error("enable changed without write");
    unimpl_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (int_rd[23:21] == 3'h0) && (int_rd[7:5] == 3'h0) && !rxp_q[0] && !rxov_q[0])
        else $error("unimplemented bit set");
    sysf_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
        evt_i.system_fault |=> int_rd[`CIFD_B_SYSF])
        else $error("system fault flag not set");
    mode_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (prime_q && operating_mode_field_i != $past(operating_mode_field_i))
        |=> int_rd[`CIFD_B_MODE])
        else $error("mode change not flagged");
    tb_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ((&time_base_counter_i) ##1 (time_base_counter_i == 32'h0000_0000))
        |=> int_rd[`CIFD_B_TBWRAP])
        else $error("time base wrap not flagged");
    rx_track_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 (rxp_q == rx_or($past(fifo_i))))
        else $error("receive pending mismatch");
    summary_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (int_rd[`CIFD_B_RXQ] == (rxp_q != 32'h0)) && (int_rd[`CIFD_B_TXQ] == (txp_q != 32'h0))
        && (int_rd[`CIFD_B_RXOVR] == (rxov_q != 32'h0)))
        else $error("summary flag mismatch");
    irq_cause_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (stk[0] && en_q[18]) |-> irq_o)
        else $error("request missing");
    code_none_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ((int_rd[15:0] & int_rd[31:16]) == 16'h0000)
        |=> (code_o.icode == `CIFD_CODE_NONE))
        else $error("code not none when idle");
    tx_code_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (txp_q == 32'h0000_0001) |=> (code_o.tx == 7'h00))
        else $error("priority queue code wrong");

    irq_seen_c:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
    clr_race_c:  cover property (@(posedge clk_i) disable iff (reset_i) |(stk_set & stk_clr));
    fifo_code_c: cover property (@(posedge clk_i) disable iff (reset_i)
        code_o.icode < `CIFD_CODE_NONE);
endmodule

// *** testbench/can_fd_interrupt_status_block_bench.sv ***
`timescale 1ns/10ps
`include "cifd_consts.svh"
module can_fd_interrupt_status_block_bench;
    import cifd_pkg::*;

    logic                    clk_i = 1'b0;
    logic                    reset_i = 1'b1;
    cifd_req_s               req;
    logic             [31:0] rdata;
    logic                    rvalid;
    cifd_evt_s               evt = '0;
    logic             [2:0]  mode = 3'h0;
    logic             [31:0] time_base_counter = 32'h0;
    cifd_fifo_s       [31:0] fifo = '0;
    logic             [31:0] txatt = 32'h0;
    logic                    teq = 1'b0;
    logic                    lnk = 1'b0;
    logic                    mem = 1'b0;
    cifd_vec_s               vec;
    cifd_code_s              code;
    logic                    irq;
    int                      bad_count = 0;
    int                      num_checks = 0;
    int                      seed = 32'h2E8D;
    logic             [31:0] en_m = 32'h0;
    logic             [31:0] fl_m = 32'h0;
    logic             [31:0] r;
    logic             [31:0] w;
    // Clear order walks the interrupt codes from highest down
    int                      clr_bit [6] = '{15, 3, 2, 12, 14, 13};

    always #2.5 clk_i = ~clk_i;

    cifd_host_model host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

    cifd_int_top DUT (
        .clk_i                  (clk_i),
        .reset_i                (reset_i),
        .reg_req_i              (req),
        .reg_rdata_o            (rdata),
        .reg_rvalid_o           (rvalid),
        .evt_i                  (evt),
        .operating_mode_field_i (mode),
        .time_base_counter_i    (time_base_counter),
        .fifo_i                 (fifo),
        .tx_attempt_vec_i       (txatt),
        .tx_event_queue_pend_i  (teq),
        .host_link_check_pend_i (lnk),
        .memory_correct_pend_i  (mem),
        .vec_o                  (vec),
        .code_o                 (code),
        .irq_o                  (irq)
    );

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] rxv(input cifd_fifo_s [31:0] f);
        rxv = '0;
        for (int n = 1; n < 32; n++)
            rxv[n] = |(f[n].rx_flag & f[n].rx_en);
    endfunction

    function automatic logic [31:0] txv(input cifd_fifo_s [31:0] f);
        for (int n = 0; n < 32; n++)
            txv[n] = |(f[n].tx_flag & f[n].tx_en);
    endfunction

    function automatic logic [31:0] ovv(input cifd_fifo_s [31:0] f);
        ovv = '0;
        for (int n = 1; n < 32; n++)
            ovv[n] = f[n].ovf;
    endfunction

    function automatic logic [6:0] top_code(input logic [31:0] v);
        top_code = `CIFD_CODE_NONE;
        for (int n = 0; n < 32; n++)
            if (v[n])
                top_code = 7'(n);
    endfunction

    function automatic logic [6:0] icode_exp(input logic [31:0] x);
        logic [15:0] p;
        p = x[15:0] & x[31:16];
        icode_exp = top_code((rxv(fifo) & {32{x[17]}}) | (txv(fifo) & {32{x[16]}}));
        if (p[13])
            icode_exp = `CIFD_CODE_BUSERR;
        if (p[14])
            icode_exp = `CIFD_CODE_WAKE;
        if (p[11])
            icode_exp = `CIFD_CODE_RXOVR;
        if (p[12])
            icode_exp = `CIFD_CODE_SYSF;
        if (p[2])
            icode_exp = `CIFD_CODE_TBWRAP;
        if (p[3])
            icode_exp = `CIFD_CODE_MODE;
        if (p[15])
            icode_exp = `CIFD_CODE_BADMSG;
        if (p[4])
            icode_exp = `CIFD_CODE_TEQ;
        if (p[10])
            icode_exp = `CIFD_CODE_TXATT;
    endfunction

    function automatic logic [31:0] word_exp();
        word_exp = en_m | fl_m;
        word_exp[11] = |ovv(fifo);
        word_exp[10] = |txatt;
        word_exp[9] = lnk;
        word_exp[8] = mem;
        word_exp[4] = teq;
        word_exp[1] = |rxv(fifo);
        word_exp[0] = |txv(fifo);
    endfunction

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic read_word();
        tick(2);
        host.rd(CIFD_SEL_INT, r);
        chk("int word", word_exp(), r);
        chk("irq", {31'h0, |(word_exp() & (word_exp() >> 16) & 32'hFFFF)}, {31'h0, irq});
        chk("icode", {25'h0, icode_exp(word_exp())}, {25'h0, code.icode});
    endtask

    initial
    begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        tick(8);
        reset_i = 1'b0;
        // Reset state and register selects, sel 3 unmapped
        for (int s = 0; s < 4; s++)
        begin
            host.rd(cifd_sel_e'(s), r);
            chk("reset read", 32'h0, r);
        end
        chk("reset codes", {11'h0, {3{`CIFD_CODE_NONE}}}, {11'h0, code});
        $display("test reset done");
        // Enable bits through byte lanes, read-only bits ignore writes
        for (int k = 0; k < 8; k++)
        begin
            w = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
            r = $random(seed);
            host.wr(CIFD_SEL_INT, (k == 0) ? 4'hF : r[3:0], w);
            for (int b = 2; b < 4; b++)
                if (k == 0 || r[b])
                    en_m[b*8 +: 8] = w[b*8 +: 8] & 8'(`CIFD_EN_MASK >> (b*8));
            host.wr(CIFD_SEL_RXP, 4'hF, 32'hFFFF_FFFF);
            read_word();
        end
        $display("test enables done");
        // Sticky hardware flags, cleared by writing zero in the low bytes
        host.wr(CIFD_SEL_INT, 4'hC, 32'hFFFF_FFFF);
        en_m = `CIFD_EN_MASK;
        for (int e = 0; e < 6; e++)
        begin
            case (e)
                0, 1, 2, 3: evt = cifd_evt_s'(4'h8 >> e);
                4: mode = mode + 3'h1;
                default: time_base_counter = 32'hFFFF_FFFF;
            endcase
            tick(1);
            evt = '0;
            time_base_counter = 32'h0;
            fl_m[(e < 4) ? 15 - e : 7 - e] = 1'b1;
            tick(3);
            read_word();
        end
        chk("code bad msg", {25'h0, `CIFD_CODE_BADMSG}, {25'h0, code.icode});
        teq = 1'b1;
        tick(3);
        chk("code teq", {25'h0, `CIFD_CODE_TEQ}, {25'h0, code.icode});
        teq = 1'b0;
        for (int e = 0; e < 6; e++)
        begin
            w = 32'hFFFF_FFFF;
            w[clr_bit[e]] = 1'b0;
            fl_m[clr_bit[e]] = 1'b0;
            host.wr(CIFD_SEL_INT, 4'h3, w);
            read_word();
        end
        $display("test flags done");
        // Random FIFO state, summaries, vectors and codes
        for (int k = 0; k < 40; k++)
        begin
            for (int n = 0; n < 32; n++)
            begin
                r = $random(seed);
                // Corner: no overflow, so FIFO codes come through
                if (k % 4 == 1)
                    r[0] = 1'b0;
                fifo[n] = cifd_fifo_s'(r[12:0] & ((k % 4 == 3) ? 13'h0 : 13'h1FFF));
            end
            // Corner: only the priority queue pending
            if (k % 4 == 3)
                fifo[0] = cifd_fifo_s'(13'h0012);
            w = $random(seed);
            txatt = (w[0] || k % 4 == 1) ? 32'h0 : $random(seed);
            teq = w[1] && (k % 4 != 1);
            lnk = w[2];
            mem = w[3];
            tick(3);
            chk("rx vec", rxv(fifo), vec.rx_queue_pending_vec);
            chk("ovf vec", ovv(fifo), vec.rx_overrun_pending_vec);
            chk("tx vec", txv(fifo), vec.tx_queue_pending_vec);
            chk("rx code", {25'h0, top_code(rxv(fifo))}, {25'h0, code.rx});
            chk("tx code", {25'h0, top_code(txv(fifo))}, {25'h0, code.tx});
            host.rd(CIFD_SEL_RXP, r);
            chk("rx reg", rxv(fifo), r);
            host.wr(CIFD_SEL_RXOV, 4'hF, 32'h0000_0000);
            host.rd(CIFD_SEL_RXOV, r);
            chk("ovf reg", ovv(fifo), r);
            read_word();
        end
        $display("test fifo done");
        tally_and_finish();
    end
endmodule

// *** testbench/cifd_host_model.sv ***
`timescale 1ns/10ps
module cifd_host_model (
    // Clock
    input  wire logic                clk_i,
    // Register port
    output cifd_pkg::cifd_req_s      req_o,
    input  wire logic         [31:0] rdata_i,
    input  wire logic                rvalid_i
);
    import cifd_pkg::*;

    initial req_o = '0;

    // Host clears a sticky flag by writing zero to it, one elsewhere
    task automatic wr(input cifd_sel_e sel, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        req_o = '{valid: 1'b1, write: 1'b1, sel: sel, be: be, wdata: d};
        @(posedge clk_i);
        #1;
        req_o = '0;
    endtask

    // Read answer waited for at most two edges; no answer gives unknown data
    task automatic rd(input cifd_sel_e sel, output logic [31:0] d);
        int n;
        d = 'x;
        @(posedge clk_i);
        #1;
        req_o = '{valid: 1'b1, write: 1'b0, sel: sel, be: 4'hF, wdata: 32'h0};
        @(posedge clk_i);
        #1;
        req_o = '0;
        for (n = 0; n < 2 && rvalid_i !== 1'b1; n++)
        begin
            @(posedge clk_i);
            #1;
        end
        if (rvalid_i === 1'b1)
        begin
            d = rdata_i;
        end
    endtask
endmodule
